// file: ascc_pkg.sv
// constants for the shared-core converter control block
package ascc_pkg;
  // register byte offsets (chosen layout, one aligned word each)
  localparam logic [4:0] OFF_CTL1L  = 5'h00;
  localparam logic [4:0] OFF_CTL1H  = 5'h04;
  localparam logic [4:0] OFF_CTL2L  = 5'h08;
  localparam logic [4:0] OFF_CTL2H  = 5'h0c;
  localparam logic [4:0] OFF_IRQST  = 5'h10;
  localparam logic [4:0] OFF_IRQMSK = 5'h14;
  // control one low
  localparam int B_MODULE_ON  = 15;
  localparam int B_IDLE_HALT  = 13;
  localparam int B_QUIET_HOLD = 7;
  // control one high
  localparam int B_FRAC       = 7;
  localparam int B_RES_LSB    = 5;
  localparam logic [1:0] RES_RESET = 2'h3;
  // control two low
  localparam int B_RDY_IE     = 15;
  localparam int B_FLT_IE     = 14;
  localparam int B_EARLY_EN   = 12;
  localparam int B_LEAD_LSB   = 8;
  // control two high
  localparam int B_RDY_FLAG   = 15;
  localparam int B_FLT_FLAG   = 14;
  // writable masks; everything else reads zero except the ready and fault flags in control two high
  localparam logic [15:0] MSK_CTL1L = 16'ha080;
  localparam logic [15:0] MSK_CTL1H = 16'h00e0;
  localparam logic [15:0] MSK_CTL2L = 16'hd77f;
  localparam logic [15:0] MSK_CTL2H = 16'h03ff;
  localparam logic [15:0] RST_CTL1H = 16'h0060;
  // interrupt status bits
  localparam int I_RDY = 0;
  localparam int I_FLT = 1;
  localparam int I_CNT = 2;
  // divider / sampling
  localparam logic [7:0] DIV_MIN    = 8'h02;
  localparam logic [10:0] SAMP_ADD  = 11'h002;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ascc_pkg

// file: ascc_seq.sv
// shared core clock divider and conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module ascc_seq (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // settings
  input  wire logic       run,
  input  wire logic       quiet_hold_en,
  input  wire logic [6:0] shared_clk_div,
  input  wire logic [9:0] shared_sample_len,
  input  wire logic [1:0] shared_resolution,
  input  wire logic [2:0] shared_early_lead,
  // partner cores
  input  wire logic       start,
  input  wire logic       other_core_done,
  // results
  output logic            core_tick,
  output logic            busy,
  output logic            early_pulse,
  output logic            done_pulse
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_SAMP = 2'b01, S_CONV = 2'b10
  } ascc_st_e;

  ascc_st_e    st_reg, st_next;
  logic [7:0]  div_reg;
  logic [10:0] cnt_reg;
  logic        hold_reg;

  function automatic logic [7:0] period_of(input logic [6:0] code);
    logic [7:0] p;
    p = {code, 1'b0};
    period_of = (p < ascc_pkg::DIV_MIN) ? ascc_pkg::DIV_MIN : p; // [R14]
  endfunction : period_of

  // conversion clocks = resolution bits
  wire [10:0] conv_len  = 11'h006 + {8'h00, shared_resolution, 1'b0}; // [R7]
  wire [10:0] lead_len  = (shared_early_lead == 3'h2 || shared_early_lead == 3'h3)
                        ? 11'h003 : {8'h00, shared_early_lead} + 11'h001; // [R12]
  wire [7:0]  period    = period_of(shared_clk_div);
  wire        tick      = run && (div_reg == period - 8'h01);
  // pause one core clock when another core finishes
  wire        stall     = hold_reg && st_reg == S_CONV; // [R4] [R5]

  assign core_tick = tick;
  assign busy      = st_reg != S_IDLE;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      S_IDLE: if (start && run) st_next = S_SAMP;
      S_SAMP: if (tick && cnt_reg == 11'h001) st_next = S_CONV;
      S_CONV: if (tick && !stall && cnt_reg == 11'h001) st_next = S_IDLE;
      default: st_next = S_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      st_reg      <= S_IDLE;
      div_reg     <= 8'h00;
      cnt_reg     <= 11'h000;
      hold_reg    <= 1'b0;
      early_pulse <= 1'b0;
      done_pulse  <= 1'b0;
    end else begin
      st_reg      <= st_next;
      div_reg     <= tick ? 8'h00 : div_reg + 8'h01;
      early_pulse <= 1'b0;
      done_pulse  <= 1'b0;
      if (quiet_hold_en && other_core_done && st_reg == S_CONV) hold_reg <= 1'b1; // [R4]
      else if (tick) hold_reg <= 1'b0;
      if (st_reg == S_IDLE && st_next == S_SAMP)
        cnt_reg <= {1'b0, shared_sample_len} + ascc_pkg::SAMP_ADD; // [R15]
      else if (tick && !stall) begin
        if (st_reg == S_SAMP && cnt_reg == 11'h001) cnt_reg <= conv_len;
        else if (cnt_reg != 11'h000) cnt_reg <= cnt_reg - 11'h001;
        if (st_reg == S_CONV && cnt_reg == lead_len + 11'h001) early_pulse <= 1'b1;
        if (st_reg == S_CONV && cnt_reg == 11'h001) done_pulse <= 1'b1;
      end
    end
  end
endmodule : ascc_seq
`default_nettype wire

// file: ascc_top.sv
// register file, interrupts and core control for the shared-core converter
// Function
// R1 - converter runs only while module_on is one
// R2 - software configures everything before setting module_on
// R3 - idle_halt stops the converter while device idle is asserted
// R4 - quiet hold pauses conversion one core clock when another core finishes
// R5 - quiet hold may stretch end of conversion by a few core clocks
// R6 - frac_format selects fractional or integer result representation
// R7 - shared_resolution codes give 12, 10, 8, 6 bits; resets to 11
// R8 - ref_ready_ie gates band gap ready onto common interrupt
// R9 - ref_fault_ie gates reference fault onto common interrupt
// R10 - software sets ref_fault_ie only after module_on
// R11 - early_irq_en picks early flag or ready flag for channel interrupts
// R12 - shared_early_lead places early interrupt 1 to 8 core clocks ahead
// R13 - software avoids long lead codes at low resolutions
// R14 - core clock period is twice divider code, minimum two
// R15 - sample time is code plus two core clocks
// R16 - ref_ready_flag follows band gap ready, resets to zero
// R17 - ref_fault_flag sets when band gap drops after module on
// R18 - unimplemented bits ignore writes and read zero
// R19 - common interrupt ORs enabled ready and fault events
`timescale 1ns/1ps
`default_nettype none
module ascc_top #(
  parameter int CHANNELS = 3
) (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite write address
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  // axi4-lite write response
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  // axi4-lite read
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [31:0]         s_axi_araddr,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  // device and reference status
  input  wire logic                device_idle,
  input  wire logic                band_gap_ok,
  // partner cores
  input  wire logic                shared_start,
  input  wire logic                other_core_done,
  input  wire logic [CHANNELS-1:0] early_status_flag,
  input  wire logic [CHANNELS-1:0] channel_ready_flag,
  // core controls
  output logic                     core_enable,
  output logic                     frac_format,
  output logic [1:0]               shared_resolution,
  output logic                     shared_core_tick,
  output logic                     shared_busy,
  output logic                     shared_early_pulse,
  output logic                     shared_done_pulse,
  // interrupts
  output logic [CHANNELS-1:0]      channel_irq,
  output logic                     common_irq,
  output logic                     irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] c1l_reg, c1h_reg, c2l_reg, c2h_sw_reg;
  logic        rdy_flag_reg, flt_flag_reg, rdy_prev_reg, on_prev_reg;
  logic [ascc_pkg::I_CNT-1:0] ist_reg, imsk_reg;
  logic        aw_hold_reg, w_hold_reg;
  logic [4:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic [CHANNELS-1:0] early_prev_reg, ready_prev_reg;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] be, input logic [15:0] msk);
    logic [15:0] n;
    n = old;
    if (be[0]) n[7:0]  = d[7:0];
    if (be[1]) n[15:8] = d[15:8];
    merge = n & msk; // [R18]
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  wire aw_have  = aw_hold_reg || s_axi_awvalid;
  wire w_have   = w_hold_reg  || s_axi_wvalid;
  wire wr_fire  = aw_have && w_have && !s_axi_bvalid;
  wire [4:0]  wa   = aw_hold_reg ? aw_addr_reg : s_axi_awaddr[4:0];
  wire [31:0] wd   = w_hold_reg  ? w_data_reg  : s_axi_wdata;
  wire [3:0]  wb   = w_hold_reg  ? w_strb_reg  : s_axi_wstrb;
  // a held address was already folded to an unmapped one, so only a live address counts
  wire        w_hi = !aw_hold_reg && |s_axi_awaddr[31:5];
  wire        wa_ok = !w_hi && (wa <= ascc_pkg::OFF_IRQMSK) && (wa[1:0] == 2'h0);
  // an error response must not touch any register
  wire        wr_ok = wr_fire && wa_ok;
  wire wr_c1l  = wr_ok && wa == ascc_pkg::OFF_CTL1L;
  wire wr_c1h  = wr_ok && wa == ascc_pkg::OFF_CTL1H;
  wire wr_c2l  = wr_ok && wa == ascc_pkg::OFF_CTL2L;
  wire wr_c2h  = wr_ok && wa == ascc_pkg::OFF_CTL2H;
  wire wr_ist  = wr_ok && wa == ascc_pkg::OFF_IRQST && wb[0];
  wire wr_imsk = wr_ok && wa == ascc_pkg::OFF_IRQMSK && wb[0];

  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      aw_addr_reg  <= 5'h00;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ascc_pkg::RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wa_ok ? ascc_pkg::RESP_OKAY : ascc_pkg::RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_hold_reg <= 1'b1;
          aw_addr_reg <= w_hi ? 5'h1f : s_axi_awaddr[4:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_hold_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers; configuration order is left to software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c1l_reg    <= 16'h0000;
      c1h_reg    <= ascc_pkg::RST_CTL1H; // [R7]
      c2l_reg    <= 16'h0000;
      c2h_sw_reg <= 16'h0000;
      imsk_reg   <= '0;
    end else begin
      if (wr_c1l) c1l_reg <= merge(c1l_reg, wd, wb, ascc_pkg::MSK_CTL1L); // [R18]
      if (wr_c1h) c1h_reg <= merge(c1h_reg, wd, wb, ascc_pkg::MSK_CTL1H);
      if (wr_c2l) c2l_reg <= merge(c2l_reg, wd, wb, ascc_pkg::MSK_CTL2L);
      if (wr_c2h) c2h_sw_reg <= merge(c2h_sw_reg, wd, wb, ascc_pkg::MSK_CTL2H);
      if (wr_imsk) imsk_reg <= wd[ascc_pkg::I_CNT-1:0];
    end
  end

  wire module_on    = c1l_reg[ascc_pkg::B_MODULE_ON];
  wire idle_halt    = c1l_reg[ascc_pkg::B_IDLE_HALT];
  wire ref_ready_ie = c2l_reg[ascc_pkg::B_RDY_IE];
  wire ref_fault_ie = c2l_reg[ascc_pkg::B_FLT_IE];
  wire early_irq_en = c2l_reg[ascc_pkg::B_EARLY_EN];
  // converter stops while off, or in idle when told to halt
  wire run = module_on && !(idle_halt && device_idle); // [R1] [R3]

  assign core_enable       = run; // [R1]
  assign frac_format       = c1h_reg[ascc_pkg::B_FRAC]; // [R6]
  assign shared_resolution = c1h_reg[ascc_pkg::B_RES_LSB +: 2]; // [R7]

  ////////////////////////////////////////////////////////////////////////////
  // reference flags and events
  wire rdy_rise  = rdy_flag_reg && !rdy_prev_reg;
  // fault only counts once the module was already on, so enabling is no event
  wire flt_event = module_on && on_prev_reg && rdy_prev_reg && !band_gap_ok; // [R17]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdy_flag_reg <= 1'b0;
      rdy_prev_reg <= 1'b0;
      flt_flag_reg <= 1'b0;
      on_prev_reg  <= 1'b0;
      ist_reg      <= '0;
    end else begin
      rdy_flag_reg <= band_gap_ok; // [R16]
      rdy_prev_reg <= rdy_flag_reg;
      on_prev_reg  <= module_on;
      if (flt_event) flt_flag_reg <= 1'b1; // [R17]
      else if (!module_on) flt_flag_reg <= 1'b0;
      // set wins over write-one-to-clear
      ist_reg[ascc_pkg::I_RDY] <= rdy_rise ||
        (ist_reg[ascc_pkg::I_RDY] && !(wr_ist && wd[ascc_pkg::I_RDY]));
      ist_reg[ascc_pkg::I_FLT] <= flt_event ||
        (ist_reg[ascc_pkg::I_FLT] && !(wr_ist && wd[ascc_pkg::I_FLT]));
    end
  end

  assign common_irq = (ref_ready_ie && rdy_flag_reg) ||
                      (ref_fault_ie && flt_flag_reg); // [R8] [R9] [R19]
  assign irq = |(ist_reg & imsk_reg &
                 {ref_fault_ie, ref_ready_ie}); // [R8] [R9]

  ////////////////////////////////////////////////////////////////////////////
  // per-channel interrupt source select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      early_prev_reg <= '0;
      ready_prev_reg <= '0;
      channel_irq    <= '0;
    end else begin
      early_prev_reg <= early_status_flag;
      ready_prev_reg <= channel_ready_flag;
      channel_irq    <= early_irq_en ? (early_status_flag & ~early_prev_reg)
                                     : (channel_ready_flag & ~ready_prev_reg); // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  ascc_seq u_seq (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .run               (run),
    .quiet_hold_en     (c1l_reg[ascc_pkg::B_QUIET_HOLD]), // [R4]
    .shared_clk_div    (c2l_reg[6:0]), // [R14]
    .shared_sample_len (c2h_sw_reg[9:0]), // [R15]
    .shared_resolution (shared_resolution),
    .shared_early_lead (c2l_reg[ascc_pkg::B_LEAD_LSB +: 3]), // [R12]
    .start             (shared_start),
    .other_core_done   (other_core_done),
    .core_tick         (shared_core_tick),
    .busy              (shared_busy),
    .early_pulse       (shared_early_pulse),
    .done_pulse        (shared_done_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read channel, one cycle latency
  wire [4:0] ra = s_axi_araddr[4:0];
  wire ra_ok = !(|s_axi_araddr[31:5]) && ra <= ascc_pkg::OFF_IRQMSK && ra[1:0] == 2'h0;
  wire [15:0] c2h_rd = c2h_sw_reg | {rdy_flag_reg, flt_flag_reg, 14'h0000}; // [R16] [R17]
  wire [15:0] rd_mux =
      (ra == ascc_pkg::OFF_CTL1L)  ? c1l_reg :
      (ra == ascc_pkg::OFF_CTL1H)  ? c1h_reg :
      (ra == ascc_pkg::OFF_CTL2L)  ? c2l_reg :
      (ra == ascc_pkg::OFF_CTL2H)  ? c2h_rd :
      (ra == ascc_pkg::OFF_IRQST)  ? {14'h0000, ist_reg} :
      (ra == ascc_pkg::OFF_IRQMSK) ? {14'h0000, imsk_reg} : 16'h0000;

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ascc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= ra_ok ? {16'h0000, rd_mux} : 32'h0000_0000;
      s_axi_rresp  <= ra_ok ? ascc_pkg::RESP_OKAY : ascc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : ascc_top
`default_nettype wire

// file: ascc_props.sv
// concurrent checks on the ports of the shared-core converter control block
`timescale 1ns/1ps
`default_nettype none
module ascc_props #(
  parameter int CHANNELS = 3
) (
  // clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // register bus answers
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic [1:0]          s_axi_rresp,
  // core side
  input wire logic                core_enable,
  input wire logic                shared_core_tick,
  input wire logic                shared_busy,
  input wire logic                shared_early_pulse,
  input wire logic                shared_done_pulse,
  input wire logic [CHANNELS-1:0] early_status_flag,
  input wire logic [CHANNELS-1:0] channel_ready_flag,
  input wire logic [CHANNELS-1:0] channel_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  rd_err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  tick_gap_a: assert property (shared_core_tick |=> !shared_core_tick)
    else $error("core clock shorter than two source clocks");
  off_quiet_a: assert property (!core_enable [*2] |-> !shared_busy && !shared_core_tick)
    else $error("converter active while off");
  done_busy_a: assert property (
    shared_done_pulse |-> $past(shared_busy) ##1 !shared_done_pulse)
    else $error("done without conversion");
  // a cut conversion never finishes, so the age clears whenever the converter stops
  logic [11:0] early_age;
  always_ff @(posedge aclk) begin
    if (!aresetn || !core_enable || shared_done_pulse) early_age <= 12'h000;
    else if (shared_early_pulse || early_age != 12'h000) early_age <= early_age + 12'h001;
  end
  // eight lead ticks of the slowest core clock plus quiet-hold stalls stay below the limit
  early_done_a: assert property (early_age != 12'hfff)
    else $error("early pulse without done");
  chan_irq_a: assert property (
    |channel_irq |-> $past(|(early_status_flag | channel_ready_flag)))
    else $error("channel interrupt without flag");
endmodule : ascc_props
bind ascc_top ascc_props #(.CHANNELS(CHANNELS)) i_props (.*);
`default_nettype wire

// file: ascc_core_model.sv
// behavioural model of the conversion cores and reference beside the control block
`timescale 1ns/1ps
`default_nettype none
module ascc_core_model (
  // clock
  input  wire logic  aclk,
  // from the control block
  input  wire logic  shared_early_pulse,
  input  wire logic  shared_done_pulse,
  // to the control block
  output logic       band_gap_ok,
  output logic       shared_start,
  output logic       other_core_done,
  output logic [2:0] early_status_flag,
  output logic [2:0] channel_ready_flag
);
  initial begin
    band_gap_ok = 1'b0;
    shared_start = 1'b0;
    other_core_done = 1'b0;
    early_status_flag = 3'h0;
    channel_ready_flag = 3'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // shared core reports on channel 2; flags drop at the next start
  always @(posedge aclk) begin
    if (shared_start) begin
      early_status_flag[2] <= 1'b0;
      channel_ready_flag[2] <= 1'b0;
    end
    if (shared_early_pulse) early_status_flag[2] <= 1'b1;
    if (shared_done_pulse) channel_ready_flag[2] <= 1'b1;
  end
  task automatic bg(input logic v);
    band_gap_ok <= v;
  endtask : bg
  task automatic cores(input logic s, input logic o);
    shared_start <= s;
    other_core_done <= o;
  endtask : cores
  task automatic flags(input logic [1:0] e, input logic [1:0] r);
    early_status_flag[1:0] <= e;
    channel_ready_flag[1:0] <= r;
  endtask : flags
endmodule : ascc_core_model
`default_nettype wire

// file: ascc_top_tb.sv
// self-checking bench for the shared-core converter control block
`timescale 1ns/1ps
`default_nettype none
module ascc_top_tb;
  logic        aclk = 1'b0, aresetn = 1'b0, device_idle = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h3;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, shared_resolution;
  logic [31:0] s_axi_rdata;
  logic        band_gap_ok, shared_start, other_core_done, core_enable, frac_format, irq;
  logic        shared_core_tick, shared_busy, shared_early_pulse, shared_done_pulse, common_irq;
  logic [2:0]  early_status_flag, channel_ready_flag, channel_irq;
  logic [15:0] msk[4] = '{16'ha080, 16'h00e0, 16'hd77f, 16'h03ff};
  int          mismatches = 0, tests_run = 0, nb0, nb, ne, tp, i;
  // res, lead, div, samp, quiet, other-done cycle, extra ticks, lead ticks, core period
  int rows[17][9] = '{'{3,0,1,0,0,0,0,1,2}, '{3,1,1,0,0,0,0,2,2}, '{3,2,1,0,0,0,0,3,2},
    '{3,3,1,0,0,0,0,3,2}, '{3,4,1,0,0,0,0,5,2}, '{3,5,1,0,0,0,0,6,2}, '{3,6,1,0,0,0,0,7,2},
    '{3,7,1,0,0,0,0,8,2}, '{3,0,0,0,0,0,0,1,2}, '{3,0,3,0,0,0,0,1,6}, '{3,0,7,0,0,0,0,1,14},
    '{3,0,1,5,0,0,5,1,2}, '{3,0,1,1023,0,0,1023,1,2}, '{2,0,1,0,0,0,-2,1,2},
    '{1,0,1,0,0,0,-4,1,2}, '{0,0,1,0,0,0,-6,1,2}, '{3,0,1,0,1,10,1,1,2}};
  always #4 aclk = ~aclk;
  ascc_top #(.CHANNELS(3)) i_dut (.*);
  ascc_core_model i_core (.*);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic stall;
    mismatches++;
    end_sim();
  endtask : stall
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // each transfer opens one edge after the last closed, so no strobe flips twice
  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {27'h0, a};
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) stall();
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr
  task automatic rc(input logic [4:0] a, input logic [15:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= {27'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    if (n >= 50) stall();
    chk(s_axi_rdata, {16'h0, e});
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rc
  task automatic cfg(input int r[9]);
    wr(5'h00, 16'h0, 2'h0);
    wr(5'h04, 16'(r[0] * 32), 2'h0);
    wr(5'h08, 16'(r[1] * 256 + r[2]), 2'h0);
    wr(5'h0c, 16'(r[3]), 2'h0);
    wr(5'h00, 16'(32'h8000 + r[4] * 128), 2'h0);
  endtask : cfg
  // busy cycles, early-to-done distance and core period of one shared conversion
  task automatic conv(input int od);
    int k, te, t0;
    te = 0;
    t0 = -1;
    tp = 0;
    nb = 0;
    for (k = 0; k < 4000; k++) begin
      @(posedge aclk);
      i_core.cores(k == 0, od > 0 && k == od);
      if (shared_busy === 1'b1) nb++;
      if (shared_core_tick === 1'b1 && tp == 0 && t0 >= 0) tp = k - t0;
      if (shared_core_tick === 1'b1) t0 = k;
      if (shared_early_pulse === 1'b1) te = k;
      if (shared_done_pulse === 1'b1) break;
    end
    if (k == 4000) stall();
    ne = k - te;
  endtask : conv
  task automatic irqs(input logic [1:0] e, input logic [1:0] r, input logic [2:0] x);
    logic [2:0] s;
    s = 3'h0;
    i_core.flags(e, r);
    repeat (6) begin
      @(posedge aclk);
      s = s | channel_irq;
    end
    chk({29'h0, s}, {29'h0, x});
  endtask : irqs
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc(5'h04, 16'h0060, 2'h0);
    rc(5'h0c, 16'h0, 2'h0);
    // control one low last so the module turns on after configuration
    for (i = 3; i >= 0; i--) begin
      wr(5'(i * 4), 16'hbfff, 2'h0);
      rc(5'(i * 4), 16'hbfff & msk[i], 2'h0);
    end
    chk({31'h0, core_enable}, 32'h1);
    chk({31'h0, frac_format}, 32'h1);
    device_idle <= 1'b1;
    @(posedge aclk);
    @(posedge aclk);
    chk({31'h0, core_enable}, 32'h0);
    wr(5'h00, 16'h8000, 2'h0);
    chk({31'h0, core_enable}, 32'h1);
    device_idle <= 1'b0;
    wr(5'h18, 16'hffff, 2'h2);
    rc(5'h18, 16'h0, 2'h2);
    i_core.bg(1'b1);
    rc(5'h0c, 16'h83ff, 2'h0);
    chk({31'h0, common_irq}, 32'h1);
    rc(5'h10, 16'h1, 2'h0);
    wr(5'h14, 16'h3, 2'h0);
    chk({31'h0, irq}, 32'h1);
    wr(5'h08, 16'h577f, 2'h0);
    chk({31'h0, common_irq}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(5'h10, 16'h1, 2'h0);
    rc(5'h10, 16'h0, 2'h0);
    i_core.bg(1'b0);
    rc(5'h0c, 16'h43ff, 2'h0);
    chk({31'h0, common_irq}, 32'h1);
    rc(5'h10, 16'h2, 2'h0);
    chk({31'h0, irq}, 32'h1);
    wr(5'h14, 16'h0, 2'h0);
    chk({31'h0, irq}, 32'h0);
    irqs(2'b01, 2'b10, 3'b001);
    irqs(2'b00, 2'b00, 3'b000);
    wr(5'h08, 16'h077f, 2'h0);
    irqs(2'b01, 2'b10, 3'b010);
    i_core.bg(1'b1);
    cfg(rows[0]);
    conv(0);
    nb0 = nb;
    for (i = 0; i < 17; i++) begin
      cfg(rows[i]);
      conv(rows[i][5]);
      chk({30'h0, shared_resolution}, 32'(rows[i][0]));
      chk({31'h0, frac_format}, 32'h0);
      chk(32'(tp), 32'(rows[i][8]));
      chk(32'(ne), 32'(rows[i][7] * rows[i][8]));
      if (rows[i][8] == 2) chk(32'(nb), 32'(nb0 + rows[i][6] * 2));
    end
    end_sim();
  end
endmodule : ascc_top_tb
`default_nettype wire
